/* design/drs_pkg.sv */
// Package of constants and types for the drive run/stop sequencer.
package drs_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [3:0] ADDR_CTRL       = 4'h0;
	localparam logic [3:0] ADDR_THRESH     = 4'h1;
	localparam logic [3:0] ADDR_CONFIRM    = 4'h2;
	localparam logic [3:0] ADDR_LOWACT     = 4'h3;
	localparam logic [3:0] ADDR_WAKE       = 4'h4;
	localparam logic [3:0] ADDR_RESTART    = 4'h5;
	localparam logic [3:0] ADDR_SETFREQ    = 4'h6;
	localparam logic [3:0] ADDR_LOWLIM     = 4'h7;
	localparam logic [3:0] ADDR_STARTFREQ  = 4'h8;
	localparam logic [3:0] ADDR_STATUS     = 4'h9;

	// ************************************************************
	// Control register fields and reset values
	// ************************************************************
	localparam int CTRL_REV_LSB   = 0;
	localparam int CTRL_SRC_BIT   = 2;
	localparam int CTRL_GUARD_BIT = 3;
	localparam int CTRL_AUTO_BIT  = 4;
	localparam int CTRL_TERM_BIT  = 5;
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0001;
	localparam logic [15:0] THRESH_RESET    = 16'h0032;
	localparam logic [15:0] CONFIRM_RESET   = 16'h0032;
	localparam logic [7:0]  LOWACT_RESET    = 8'h00;
	localparam logic [7:0]  LOWACT_MAX      = 8'h12;
	localparam logic [15:0] WAKE_RESET      = 16'h0000;
	localparam logic [15:0] RESTART_RESET   = 16'h000A;
	localparam logic [15:0] RESTART_MAX     = 16'h8CA0;
	localparam logic [15:0] HUNDREDTHS_MAX  = 16'h2710;

	// ************************************************************
	// Reversal modes and low-limit actions
	// ************************************************************
	localparam logic [1:0] REV_AT_ZERO  = 2'h0;
	localparam logic [1:0] REV_AT_START = 2'h1;
	localparam logic [1:0] REV_AT_STOP  = 2'h2;
	localparam logic [3:0] LOW_RUN      = 4'h0;
	localparam logic [3:0] LOW_STOP     = 4'h1;
	localparam logic [3:0] LOW_SLEEP    = 4'h2;

	// ************************************************************
	// Timing: 10 ms tick from the 200 MHz reference clock
	// ************************************************************
	localparam int CLK_HZ        = 200_000_000;
	localparam int TICK_MS       = 10;
	localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
	localparam int RESTART_DIV   = 10;

	typedef enum logic [5:0] {
		ST_INIT    = 6'h01,
		ST_GUARD   = 6'h02,
		ST_WAIT    = 6'h04,
		ST_IDLE    = 6'h08,
		ST_RUN     = 6'h10,
		ST_LOWSTOP = 6'h20
	} drs_state_type;

endpackage

/* design/drs_timer.sv */
// Qualifying timer: counts ticks while a condition holds, reports once a limit is reached.
module drs_timer #(
	parameter int WIDTH = 16
) (
	// Clock and reset
	input  wire logic             ref_clk,
	input  wire logic             resetn,
	// Control
	input  wire logic             tick,
	input  wire logic             hold,
	input  wire logic [WIDTH-1:0] limit,
	// Result
	output logic                  done
);

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             armed;
		logic             done;
	} drs_timer_state_type;

	drs_timer_state_type tmr_r;
	drs_timer_state_type tmr_nxt;

	always_comb begin
		tmr_nxt = tmr_r;
		if (!hold) begin
			tmr_nxt.count = '0;
			tmr_nxt.armed = 1'b0;
			tmr_nxt.done  = 1'b0;
		end else if (tmr_r.count >= limit) begin
			tmr_nxt.done = 1'b1;
		end else if (tick && !tmr_r.armed) begin
			// The first tick only aligns to the tick grid, so a partial period never counts.
			tmr_nxt.armed = 1'b1;
		end else if (tick) begin
			tmr_nxt.count = tmr_r.count + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tmr_r <= '0;
		end else begin
			tmr_r <= tmr_nxt;
		end
	end

	assign done = tmr_r.done;

endmodule // drs_timer

/* design/drs_sequencer.sv */
// Run/stop sequencer of a variable-frequency drive with its register port.
//
// Behaviour
// - Direction reversal point: 0 zero freq, 1 start freq, 2 stop speed plus delay.
// - Stop speed threshold 0.00-100.00 Hz, default 0.50, set or feedback speed.
// - Power-up run guard applies only with terminal command source.
// - Guard code 0: terminal run active at power-up ignored until removed and reasserted.
// - Guard code 1: terminal run active at power-up starts after initialisation.
// - Below nonzero lower limit, ones digit picks run at limit, stop or sleep.
// - For stop or sleep, tens digit picks coast or ramp stop.
// - After low-frequency stop, resume once set freq above limit for wake delay.
// - Auto restart 0 runs after power return only once the command is reasserted; 1 runs after wait.
// - Restart wait, default 1.0 s, holds off output after re-power-on.
// - Restart wait settable 0.0-3600.0 s, used only when auto restart enabled.
module drs_sequencer #(
	parameter int TICK_CYCLES = drs_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Register port
	input  wire logic [3:0]  regAddr,
	input  wire logic [31:0] regWdata,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	output logic      [31:0] regRdata,
	// Run command and speed
	input  wire logic        runCmd,
	input  wire logic        dirCmd,
	input  wire logic [15:0] speedFeedback,
	input  wire logic [15:0] outFreq,
	input  wire logic        initDone,
	input  wire logic        powerReturn,
	// Output stage control
	output logic             runEnable,
	output logic             rampStop,
	output logic             coastStop,
	output logic             dirOut,
	output logic             atStopSpeed,
	output logic             sleeping
);

	// ************************************************************
	// State codes
	// ************************************************************
	localparam drs_pkg::drs_state_type ST_INIT_L    = drs_pkg::ST_INIT;
	localparam drs_pkg::drs_state_type ST_GUARD_L   = drs_pkg::ST_GUARD;
	localparam drs_pkg::drs_state_type ST_WAIT_L    = drs_pkg::ST_WAIT;
	localparam drs_pkg::drs_state_type ST_IDLE_L    = drs_pkg::ST_IDLE;
	localparam drs_pkg::drs_state_type ST_RUN_L     = drs_pkg::ST_RUN;
	localparam drs_pkg::drs_state_type ST_LOWSTOP_L = drs_pkg::ST_LOWSTOP;

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [31:0]           ctrl;
		logic [15:0]           thresh;
		logic [15:0]           confirm;
		logic [7:0]            lowAct;
		logic [15:0]           wake;
		logic [15:0]           restart;
		logic [15:0]           setFreq;
		logic [15:0]           lowLim;
		logic [15:0]           startFreq;
		logic [31:0]           rdata;
		logic [31:0]           tickCnt;
		logic                  tick;
		logic [3:0]            sub;
		logic                  sleep;
		logic                  blockRun;
		drs_pkg::drs_state_type st;
		logic                  runEn;
		logic                  ramp;
		logic                  coast;
		logic                  dir;
		logic                  stopSpd;
	} drs_seq_state_type;

	drs_seq_state_type s_r;
	drs_seq_state_type s_nxt;

	logic stopDone;
	logic wakeDone;
	logic waitDone;
	logic [15:0] cmpSpeed;
	logic        belowLow;
	logic        revPointOk;
	logic        waitTick;

	// Threshold, confirm, low-action and restart writes clamp to the documented ranges.
	function automatic logic [15:0] clampHund(input logic [15:0] v, input logic [15:0] mx);
		clampHund = (v > mx) ? mx : v;
	endfunction

	// ************************************************************
	// Speed comparison and qualifying timers
	// ************************************************************
	// Set-speed compare is meant for V/F control; feedback is used when selected.
	assign cmpSpeed = s_r.ctrl[drs_pkg::CTRL_SRC_BIT] ? speedFeedback : outFreq;
	assign belowLow = (s_r.lowLim != '0) && (s_r.setFreq < s_r.lowLim);
	assign waitTick = s_r.tick && (s_r.sub == 4'(drs_pkg::RESTART_DIV - 1));

	drs_timer #(.WIDTH(16)) u_stop (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.tick    (s_r.tick),
		.hold    (cmpSpeed <= s_r.thresh),
		.limit   (s_r.confirm),
		.done    (stopDone)
	);

	drs_timer #(.WIDTH(16)) u_wake (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.tick    (waitTick),
		.hold    (s_r.st == ST_LOWSTOP_L && !belowLow),
		.limit   (s_r.wake),
		.done    (wakeDone)
	);

	drs_timer #(.WIDTH(16)) u_wait (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.tick    (waitTick),
		.hold    (s_r.st == ST_WAIT_L),
		.limit   (s_r.restart),
		.done    (waitDone)
	);

	// Reversal point per mode.
	always_comb begin
		case (s_r.ctrl[drs_pkg::CTRL_REV_LSB +: 2])
			drs_pkg::REV_AT_ZERO:  revPointOk = (outFreq == '0);
			drs_pkg::REV_AT_START: revPointOk = (outFreq <= s_r.startFreq);
			drs_pkg::REV_AT_STOP:  revPointOk = stopDone;
			default:               revPointOk = (outFreq <= s_r.startFreq);
		endcase
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_nxt = s_r;
		// A command held through power return with restart off must drop before it starts.
		if (!runCmd) begin
			s_nxt.blockRun = 1'b0;
		end
		s_nxt.stopSpd = stopDone;
		s_nxt.tick = 1'b0;
		if (s_r.tickCnt >= 32'(TICK_CYCLES - 1)) begin
			s_nxt.tickCnt = '0;
			s_nxt.tick    = 1'b1;
		end else begin
			s_nxt.tickCnt = s_r.tickCnt + 32'h0000_0001;
		end
		if (s_r.tick) begin
			s_nxt.sub = (s_r.sub == 4'(drs_pkg::RESTART_DIV - 1)) ? 4'h0 : s_r.sub + 4'h1;
		end

		// Register port.
		s_nxt.rdata = 32'h0000_0000;
		if (regWrite) begin
			case (regAddr)
				drs_pkg::ADDR_CTRL:      s_nxt.ctrl = regWdata;
				drs_pkg::ADDR_THRESH:    s_nxt.thresh = clampHund(regWdata[15:0],
					drs_pkg::HUNDREDTHS_MAX);
				drs_pkg::ADDR_CONFIRM:   s_nxt.confirm = clampHund(regWdata[15:0],
					drs_pkg::HUNDREDTHS_MAX);
				drs_pkg::ADDR_LOWACT:    s_nxt.lowAct = (regWdata[7:0] > drs_pkg::LOWACT_MAX)
					? drs_pkg::LOWACT_MAX
					: regWdata[7:0];
				drs_pkg::ADDR_WAKE:      s_nxt.wake = regWdata[15:0];
				drs_pkg::ADDR_RESTART:   s_nxt.restart = clampHund(regWdata[15:0],
					drs_pkg::RESTART_MAX);
				drs_pkg::ADDR_SETFREQ:   s_nxt.setFreq = regWdata[15:0];
				drs_pkg::ADDR_LOWLIM:    s_nxt.lowLim = regWdata[15:0];
				drs_pkg::ADDR_STARTFREQ: s_nxt.startFreq = regWdata[15:0];
				default: ;
			endcase
		end
		if (regRead) begin
			case (regAddr)
				drs_pkg::ADDR_CTRL:      s_nxt.rdata = s_r.ctrl;
				drs_pkg::ADDR_THRESH:    s_nxt.rdata = {16'h0000, s_r.thresh};
				drs_pkg::ADDR_CONFIRM:   s_nxt.rdata = {16'h0000, s_r.confirm};
				drs_pkg::ADDR_LOWACT:    s_nxt.rdata = {24'h000000, s_r.lowAct};
				drs_pkg::ADDR_WAKE:      s_nxt.rdata = {16'h0000, s_r.wake};
				drs_pkg::ADDR_RESTART:   s_nxt.rdata = {16'h0000, s_r.restart};
				drs_pkg::ADDR_SETFREQ:   s_nxt.rdata = {16'h0000, s_r.setFreq};
				drs_pkg::ADDR_LOWLIM:    s_nxt.rdata = {16'h0000, s_r.lowLim};
				drs_pkg::ADDR_STARTFREQ: s_nxt.rdata = {16'h0000, s_r.startFreq};
				drs_pkg::ADDR_STATUS:    s_nxt.rdata = {20'h00000, s_r.sleep, s_r.stopSpd,
					s_r.coast, s_r.ramp, s_r.runEn, 1'b0, s_r.st};
				default:                 s_nxt.rdata = 32'h0000_0000;
			endcase
		end

		// Direction follows the command at the chosen reversal point or while the drive is not running.
		if (dirCmd != s_r.dir && (revPointOk || !s_r.runEn)) begin
			s_nxt.dir = dirCmd;
		end

		case (s_r.st)
			ST_INIT_L: begin
				if (initDone) begin
					if (powerReturn) begin
						// A run after power loss waits only when restart is enabled.
						s_nxt.st = s_r.ctrl[drs_pkg::CTRL_AUTO_BIT] ? ST_WAIT_L
							: ST_IDLE_L;
						s_nxt.blockRun = !s_r.ctrl[drs_pkg::CTRL_AUTO_BIT];
					end else if (s_r.ctrl[drs_pkg::CTRL_TERM_BIT] && runCmd) begin
						s_nxt.st = s_r.ctrl[drs_pkg::CTRL_GUARD_BIT] ? ST_RUN_L
							: ST_GUARD_L;
					end else begin
						s_nxt.st = ST_IDLE_L;
					end
				end
			end
			ST_GUARD_L: begin
				if (!runCmd) begin
					s_nxt.st = ST_IDLE_L;
				end
			end
			ST_WAIT_L: begin
				if (waitDone) begin
					s_nxt.st = runCmd ? ST_RUN_L : ST_IDLE_L;
				end
			end
			ST_IDLE_L: begin
				if (runCmd && !s_r.blockRun) begin
					s_nxt.st = ST_RUN_L;
				end
			end
			ST_RUN_L: begin
				if (!runCmd) begin
					s_nxt.st = ST_IDLE_L;
				end else if (belowLow && s_r.lowAct[3:0] != drs_pkg::LOW_RUN) begin
					s_nxt.st    = ST_LOWSTOP_L;
					s_nxt.sleep = (s_r.lowAct[3:0] == drs_pkg::LOW_SLEEP);
				end
			end
			ST_LOWSTOP_L: begin
				if (!runCmd) begin
					s_nxt.st    = ST_IDLE_L;
					s_nxt.sleep = 1'b0;
				end else if (wakeDone) begin
					s_nxt.st    = ST_RUN_L;
					s_nxt.sleep = 1'b0;
				end
			end
			default: s_nxt.st = ST_INIT_L;
		endcase

		s_nxt.runEn = (s_nxt.st == ST_RUN_L);
		s_nxt.ramp  = !s_nxt.runEn && (s_nxt.st == ST_LOWSTOP_L) && s_nxt.lowAct[4];
		s_nxt.coast = !s_nxt.runEn && (s_nxt.st == ST_LOWSTOP_L) && !s_nxt.lowAct[4];
		if (s_nxt.st == ST_IDLE_L && s_r.runEn) begin
			s_nxt.ramp = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s_r           <= '0;
			s_r.ctrl      <= drs_pkg::CTRL_RESET;
			s_r.thresh    <= drs_pkg::THRESH_RESET;
			s_r.confirm   <= drs_pkg::CONFIRM_RESET;
			s_r.lowAct    <= drs_pkg::LOWACT_RESET;
			s_r.wake      <= drs_pkg::WAKE_RESET;
			s_r.restart   <= drs_pkg::RESTART_RESET;
			s_r.st        <= ST_INIT_L;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign regRdata    = s_r.rdata;
	assign runEnable   = s_r.runEn;
	assign rampStop    = s_r.ramp;
	assign coastStop   = s_r.coast;
	assign dirOut      = s_r.dir;
	assign atStopSpeed = s_r.stopSpd;
	assign sleeping    = s_r.sleep;

	// ************************************************************
	// Checks
	// ************************************************************
	chk_guard_holds: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_GUARD_L && runCmd |=> !runEnable)
		else $error("run started while power-up guard active");
	chk_guard_release: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_GUARD_L && !runCmd |=> s_r.st == ST_IDLE_L)
		else $error("guard not released on command removal");
	chk_auto_start: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_INIT_L && initDone && !powerReturn && runCmd
		&& s_r.ctrl[drs_pkg::CTRL_TERM_BIT] && s_r.ctrl[drs_pkg::CTRL_GUARD_BIT]
		|=> runEnable)
		else $error("guard code 1 did not start drive");
	chk_no_restart: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_INIT_L && initDone && powerReturn
		&& !s_r.ctrl[drs_pkg::CTRL_AUTO_BIT] |=> s_r.st == ST_IDLE_L)
		else $error("restart without enable");
	chk_wait_blocks: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_WAIT_L |-> !runEnable)
		else $error("output during restart wait");
	chk_low_stop: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_RUN_L && runCmd && belowLow && s_r.lowAct[3:0] == drs_pkg::LOW_STOP
		|=> !runEnable && !sleeping)
		else $error("low-limit stop not taken");
	chk_stop_mode: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_LOWSTOP_L |-> rampStop == s_r.lowAct[4] && coastStop != s_r.lowAct[4])
		else $error("wrong stop method");
	chk_stop_speed: assert property (@(posedge ref_clk) disable iff (!resetn)
		atStopSpeed |-> $past(cmpSpeed <= s_r.thresh, 2))
		else $error("stop speed without qualification");
	chk_threshold_range: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.thresh <= drs_pkg::HUNDREDTHS_MAX)
		else $error("threshold out of range");
	chk_restart_range: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.restart <= drs_pkg::RESTART_MAX)
		else $error("restart wait out of range");
	chk_restart_block: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_IDLE_L && s_r.blockRun |=> !runEnable)
		else $error("held command restarted the drive");
	chk_dir_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		runEnable && !revPointOk |=> $stable(dirOut))
		else $error("direction changed away from reversal point");
	chk_sleep_entry: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_RUN_L && runCmd && belowLow && s_r.lowAct[3:0] == drs_pkg::LOW_SLEEP
		|=> !runEnable && sleeping)
		else $error("low-limit sleep not taken");
	chk_wake_resume: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_LOWSTOP_L && runCmd && wakeDone |=> runEnable && !sleeping)
		else $error("no resume after wake delay");
	chk_wait_release: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_r.st == ST_WAIT_L && waitDone && runCmd |=> runEnable)
		else $error("no run after restart wait");

endmodule // drs_sequencer

/* verification/drs_motor_model.sv */
// Behavioural model of the motor output stage driven by the sequencer.
module drs_motor_model (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Drive commands
	input  wire logic        runEnable,
	input  wire logic        rampStop,
	input  wire logic        coastStop,
	input  wire logic [15:0] targetFreq,
	// Motor state
	output logic      [15:0] outFreq,
	output logic      [15:0] speedFeedback
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [15:0] STEP = 16'h0064;
	localparam logic [15:0] DECAY = 16'h0019;

	// The shaft keeps turning after a coast stop, so feedback decays slowly.
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			outFreq <= 16'h0000;
			speedFeedback <= 16'h0000;
		end else begin
			if (coastStop || (!runEnable && !rampStop)) begin
				outFreq <= 16'h0000;
			end else if (rampStop || outFreq > targetFreq) begin
				outFreq <= (outFreq > STEP) ? outFreq - STEP : 16'h0000;
			end else if (outFreq < targetFreq) begin
				outFreq <= (targetFreq - outFreq > STEP) ? outFreq + STEP : targetFreq;
			end
			if (speedFeedback > outFreq + DECAY) begin
				speedFeedback <= speedFeedback - DECAY;
			end else begin
				speedFeedback <= outFreq;
			end
		end
	end
endmodule // drs_motor_model

/* verification/drs_sequencer_tb.sv */
// Self-checking testbench of the drive run/stop sequencer.
module drs_sequencer_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICKS = 4;
	localparam int LIMIT = 20000;
	logic ref_clk, resetn, regWrite, regRead, runCmd, dirCmd, initDone, powerReturn;
	logic [3:0] regAddr;
	logic [31:0] regWdata, regRdata, rd;
	logic [15:0] speedFeedback, outFreq, targetFreq;
	logic runEnable, rampStop, coastStop, dirOut, atStopSpeed, sleeping;
	logic [5:0] outs;
	int errors, checked, cycles;
	assign outs = {runEnable, rampStop, coastStop, sleeping, atStopSpeed, dirOut};

	// ************************************************************
	// Design and far side
	// ************************************************************
	drs_sequencer #(.TICK_CYCLES(TICKS)) dut (.ref_clk(ref_clk), .resetn(resetn),
		.regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .runCmd(runCmd), .dirCmd(dirCmd),
		.speedFeedback(speedFeedback), .outFreq(outFreq), .initDone(initDone),
		.powerReturn(powerReturn), .runEnable(runEnable), .rampStop(rampStop),
		.coastStop(coastStop), .dirOut(dirOut), .atStopSpeed(atStopSpeed),
		.sleeping(sleeping));
	drs_motor_model motor (.ref_clk(ref_clk), .resetn(resetn), .runEnable(runEnable),
		.rampStop(rampStop), .coastStop(coastStop), .targetFreq(targetFreq),
		.outFreq(outFreq), .speedFeedback(speedFeedback));

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask
	task automatic rdreg(input logic [3:0] a);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		rd = regRdata;
	endtask
	// Reach mode waits for the pattern; otherwise the pattern must stay absent.
	task automatic watch(input logic [5:0] m, input logic [5:0] v, input int n, input bit reach);
		bit hit;
		hit = 1'b0;
		for (int i = 0; i < n && !(reach && hit); i++) begin
			@(posedge ref_clk);
			#1;
			if ((outs & m) === v) hit = 1'b1;
		end
		// Return on an edge so that callers drive inputs on the rising edge.
		@(posedge ref_clk);
		chk({31'h0, hit}, {31'h0, reach});
	endtask
	task automatic do_reset();
		@(posedge ref_clk);
		resetn <= 1'b0;
		repeat (10) @(posedge ref_clk);
		chk({26'h0, outs}, 32'h0);
		resetn <= 1'b1;
	endtask
	task automatic power_up(input logic [31:0] ctrl, input logic run, input logic pret);
		initDone <= 1'b0;
		runCmd <= run;
		powerReturn <= pret;
		do_reset();
		wr(drs_pkg::ADDR_RESTART, 32'h2);
		wr(drs_pkg::ADDR_CTRL, ctrl);
		@(posedge ref_clk);
		initDone <= 1'b1;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ************************************************************
	// Clock and timeout
	// ************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			errors++;
			$display("[ERR] %0t timeout", $time);
			close_out();
		end
	end

	// ************************************************************
	// Tables
	// ************************************************************
	logic [3:0]  rowAddr[7] = '{4'h1, 4'h1, 4'h2, 4'h5, 4'h3, 4'h0, 4'hF};
	logic [31:0] rowData[7] = '{32'h2710, 32'h2711, 32'h2711, 32'h8CA1, 32'h12, 32'h22, 32'h1234};
	logic [31:0] rowExp[7]  = '{32'h2710, 32'h2710, 32'h2710, 32'h8CA0, 32'h12, 32'h22, 32'h0};
	logic [3:0]  rstAddr[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5};
	logic [31:0] rstExp[6]  = '{drs_pkg::CTRL_RESET, {16'h0, drs_pkg::THRESH_RESET},
		{16'h0, drs_pkg::CONFIRM_RESET}, {24'h0, drs_pkg::LOWACT_RESET},
		{16'h0, drs_pkg::WAKE_RESET}, {16'h0, drs_pkg::RESTART_RESET}};
	logic [31:0] lowAct[5]  = '{32'h00, 32'h01, 32'h11, 32'h02, 32'h12};
	logic [5:0]  lowMask[5] = '{6'h3C, 6'h1C, 6'h1C, 6'h1C, 6'h1C};
	logic [5:0]  lowVal[5]  = '{6'h20, 6'h08, 6'h10, 6'h0C, 6'h14};

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{regWrite, regRead, runCmd, dirCmd, powerReturn, resetn} = 6'h00;
		{regAddr, regWdata, targetFreq} = 52'h0;
		initDone = 1'b1;
		errors = 0;
		checked = 0;
		cycles = 0;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			wr(rowAddr[i], rowData[i]);
			rdreg(rowAddr[i]);
			chk(rd, rowExp[i]);
		end
		$display("register table done");
		wr(drs_pkg::ADDR_CTRL, 32'h0);
		dirCmd <= 1'b1;
		watch(6'h01, 6'h01, 20, 1'b1);
		wr(drs_pkg::ADDR_CTRL, 32'h1);
		dirCmd <= 1'b0;
		watch(6'h01, 6'h00, 20, 1'b1);
		wr(drs_pkg::ADDR_STARTFREQ, 32'h64);
		targetFreq <= 16'h03E8;
		runCmd <= 1'b1;
		repeat (20) @(posedge ref_clk);
		dirCmd <= 1'b1;
		watch(6'h01, 6'h01, 20, 1'b0);
		targetFreq <= 16'h0000;
		watch(6'h01, 6'h01, 30, 1'b1);
		runCmd <= 1'b0;
		dirCmd <= 1'b0;
		repeat (20) @(posedge ref_clk);
		$display("reversal done");
		wr(drs_pkg::ADDR_LOWLIM, 32'h1F4);
		for (int i = 0; i < 5; i++) begin
			wr(drs_pkg::ADDR_LOWACT, lowAct[i]);
			wr(drs_pkg::ADDR_SETFREQ, 32'h3E8);
			targetFreq <= 16'h03E8;
			runCmd <= 1'b1;
			watch(6'h20, 6'h20, 30, 1'b1);
			wr(drs_pkg::ADDR_SETFREQ, 32'hC8);
			targetFreq <= 16'h00C8;
			watch(lowMask[i], lowVal[i], 60, 1'b1);
			wr(drs_pkg::ADDR_SETFREQ, 32'h3E8);
			watch(6'h24, 6'h20, 60, 1'b1);
			runCmd <= 1'b0;
			repeat (60) @(posedge ref_clk);
		end
		wr(drs_pkg::ADDR_WAKE, 32'h1);
		wr(drs_pkg::ADDR_LOWACT, 32'h02);
		wr(drs_pkg::ADDR_SETFREQ, 32'hC8);
		runCmd <= 1'b1;
		watch(6'h04, 6'h04, 60, 1'b1);
		wr(drs_pkg::ADDR_SETFREQ, 32'h3E8);
		watch(6'h20, 6'h20, 25, 1'b0);
		watch(6'h20, 6'h20, 60, 1'b1);
		runCmd <= 1'b0;
		$display("low limit done");
		do_reset();
		for (int i = 0; i < 6; i++) begin
			rdreg(rstAddr[i]);
			chk(rd, rstExp[i]);
		end
		watch(6'h02, 6'h02, 140, 1'b0);
		watch(6'h02, 6'h02, 120, 1'b1);
		$display("reset values done");
		power_up(32'h20, 1'b1, 1'b0);
		watch(6'h20, 6'h20, 60, 1'b0);
		runCmd <= 1'b0;
		repeat (5) @(posedge ref_clk);
		runCmd <= 1'b1;
		watch(6'h20, 6'h20, 30, 1'b1);
		power_up(32'h28, 1'b1, 1'b0);
		watch(6'h20, 6'h20, 30, 1'b1);
		power_up(32'h00, 1'b1, 1'b0);
		watch(6'h20, 6'h20, 30, 1'b1);
		$display("power-up guard done");
		power_up(32'h10, 1'b1, 1'b1);
		watch(6'h20, 6'h20, 80, 1'b0);
		watch(6'h20, 6'h20, 60, 1'b1);
		power_up(32'h00, 1'b1, 1'b1);
		watch(6'h20, 6'h20, 150, 1'b0);
		$display("auto restart done");
		close_out();
	end
endmodule // drs_sequencer_tb
